// ===== rtl/tocp_defs.svh
// register offsets, reset values and field positions of the compare block
//
// Summary of operation
// - compare equal to counter sets channel flag and drives enabled pin to level
// - each 16-bit compare value not held off by a high byte write is checked against the counter every timer step
// - compare values are software read/write and never changed by hardware
// - reset loads both compare values with 8000h
// - compare interrupt needs its enable set and the cpu mask clear
// - compare pin latches are held low during reset
// - flag clears after status read with flag set, then low byte access
// - high byte write stops compares until low byte write, which clears flag
// - with pin enable clear the pin is untouched, flag and interrupt still work
// - flag and pin level appear in the step where counter equals compare
// - force bit copies level to enabled pin, no flag and no interrupt
// - force bits do nothing in single-pulse or pwm mode
// - count rate is clock over 2, 4, 8 or external clock edges
// - single-pulse select bit in control two enables single-pulse mode
// - trigger edge reloads FFFCh, drives level two, sets capture flag, loads FFFDh
// - capture flag one raises interrupt when capture interrupt enable is set
// - in single-pulse mode a channel one match drives level one
// - single-pulse mode never sets flag one, flag two still works
// - pwm select together with single-pulse select means pwm only
// - single-pulse trigger pin does no capture, each valid edge resets counter
// - channel two in single-pulse mode keeps its flag but drives no pin
// - pulse lasts compare one plus 5 counts because of the FFFCh restart
// - counter resets to FFFCh and only ever reloads FFFCh
`ifndef TOCP_DEFS_SVH
`define TOCP_DEFS_SVH

`define TOCP_OFS_CTRL_ONE   8'h00
`define TOCP_OFS_CTRL_TWO   8'h04
`define TOCP_OFS_STATUS     8'h08
`define TOCP_OFS_CMP1_HI    8'h0c
`define TOCP_OFS_CMP1_LO    8'h10
`define TOCP_OFS_CMP2_HI    8'h14
`define TOCP_OFS_CMP2_LO    8'h18
`define TOCP_OFS_CAP1_HI    8'h1c
`define TOCP_OFS_CAP1_LO    8'h20
`define TOCP_OFS_COUNTER    8'h24

`define TOCP_CMP_RESET      16'h8000
`define TOCP_CNT_RELOAD     16'hfffc
`define TOCP_CAP_TRIG_VAL   16'hfffd
`define TOCP_CNT_ONE        16'h0001

`define TOCP_CLK_DIV2       2'h0
`define TOCP_CLK_DIV4       2'h1
`define TOCP_CLK_DIV8       2'h2
`define TOCP_CLK_EXT        2'h3
`define TOCP_DIV2_LAST      3'h1
`define TOCP_DIV4_LAST      3'h3
`define TOCP_DIV8_LAST      3'h7

`define TOCP_PIN_EXT        0
`define TOCP_PIN_CAP1       1

`endif

// ===== rtl/tocp_pkg.sv
// types shared by the compare block modules
package tocp_pkg;

    // control register one as software sees it
    typedef struct packed {
        logic       edge_one;
        logic       cap_ie;
        logic       cmp_ie;
        logic [1:0] level;
    } tocp_ctrl_one_type;

    // control register two as software sees it
    typedef struct packed {
        logic       ext_rise;
        logic [1:0] clk_sel;
        logic       pwm_sel;
        logic       sp_sel;
        logic [1:0] pin_en;
    } tocp_ctrl_two_type;

    // whole state of the top module
    typedef struct packed {
        tocp_ctrl_one_type ctrl_one;
        tocp_ctrl_two_type ctrl_two;
        logic [1:0][15:0]  cmp;
        logic [1:0]        inhibit;
        logic [1:0]        flag;
        logic              cap_flag;
        logic [2:0]        armed;
        logic [15:0]       cap_val;
        logic [15:0]       counter;
        logic              stepped;
        logic              hold;
        logic [1:0]        pin;
        logic              reinit;
        logic              irq;
        logic              dp_write;
        logic [7:0]        dp_addr;
        logic [31:0]       rdata;
        logic              ready;
    } tocp_state_type;

    // state of the pin filter
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] filt;
        logic [1:0] rise;
        logic [1:0] fall;
    } tocp_sync_type;

    // state of the count-rate divider
    typedef struct packed {
        logic [2:0] div;
        logic       tick;
    } tocp_presc_type;

endpackage

// ===== rtl/tocp_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`include "tocp_defs.svh"
module tocp_sync import tocp_pkg::*; (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] level,
    output logic      [1:0] rise,
    output logic      [1:0] fall
);
    tocp_sync_type s_reg, s_next;

    // a new level is taken only once stages two and three agree
    always_comb begin
        s_next = s_reg;
        s_next.s1 = pin_in;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < 2; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.filt[i] = s_reg.s3[i];
            end
            s_next.rise[i] = s_next.filt[i] & ~s_reg.filt[i];
            s_next.fall[i] = ~s_next.filt[i] & s_reg.filt[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.filt;
    assign rise  = s_reg.rise;
    assign fall  = s_reg.fall;
endmodule

// ===== rtl/tocp_presc.sv
// count-rate divider: one-cycle tick at clock/2, /4, /8 or per external edge
`timescale 1ns/10ps
`include "tocp_defs.svh"
module tocp_presc import tocp_pkg::*; (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] clk_sel,
    input  wire logic       ext_edge,
    output logic            tick
);
    tocp_presc_type s_reg, s_next;
    logic [2:0] last;

    // terminal count for the selected division
    always_comb begin
        case (clk_sel)
            `TOCP_CLK_DIV2: last = `TOCP_DIV2_LAST;
            `TOCP_CLK_DIV4: last = `TOCP_DIV4_LAST;
            default:        last = `TOCP_DIV8_LAST;
        endcase
    end

    // external clock bypasses the divider entirely
    always_comb begin
        s_next = s_reg;
        if (clk_sel == `TOCP_CLK_EXT) begin
            s_next.div  = '0;
            s_next.tick = ext_edge;
        end else if (s_reg.div >= last) begin
            s_next.div  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div  = s_reg.div + 3'h1;
            s_next.tick = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// ===== rtl/tocp_top.sv
// output compare and single-pulse section of the 16-bit timer, ahb-lite slave
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "tocp_defs.svh"
module tocp_top import tocp_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        cpu_irq_mask,
    input  wire logic        ext_clock_pin,
    input  wire logic        capture_input_pin_one,
    output logic             compare_output_pin_one,
    output logic             compare_output_pin_two,
    output logic [1:0]       compare_pin_enable,
    output logic             counter_reinit,
    output logic             timer_irq
);
    tocp_state_type s_reg, s_next;

    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic       tick;
    logic       ext_edge;
    logic       addr_phase;
    logic       sp_mode;
    logic       pwm_mode;
    logic       trig;
    logic [1:0] match;
    logic [7:0] ap_addr;

    // external clock and trigger pin come from outside the clock domain
    tocp_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({capture_input_pin_one, ext_clock_pin}),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // active external edge follows the edge select bit
    assign ext_edge = s_reg.ctrl_two.ext_rise ? pin_rise[`TOCP_PIN_EXT]
                                              : pin_fall[`TOCP_PIN_EXT];

    tocp_presc u_presc (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_sel  (s_reg.ctrl_two.clk_sel),
        .ext_edge (ext_edge),
        .tick     (tick)
    );

    // read data of a register, used for the registered read answer
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input tocp_state_type st);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `TOCP_OFS_CTRL_ONE: w[6:0]  = {st.ctrl_one.edge_one, st.ctrl_one.cap_ie,
                                           st.ctrl_one.cmp_ie, 2'b00, st.ctrl_one.level};
            `TOCP_OFS_CTRL_TWO: w[6:0]  = st.ctrl_two;
            `TOCP_OFS_STATUS:   w[2:0]  = {st.cap_flag, st.flag};
            `TOCP_OFS_CMP1_HI:  w[7:0]  = st.cmp[0][15:8];
            `TOCP_OFS_CMP1_LO:  w[7:0]  = st.cmp[0][7:0];
            `TOCP_OFS_CMP2_HI:  w[7:0]  = st.cmp[1][15:8];
            `TOCP_OFS_CMP2_LO:  w[7:0]  = st.cmp[1][7:0];
            `TOCP_OFS_CAP1_HI:  w[7:0]  = st.cap_val[15:8];
            `TOCP_OFS_CAP1_LO:  w[7:0]  = st.cap_val[7:0];
            `TOCP_OFS_COUNTER:  w[15:0] = st.counter;
            default:            w       = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // low byte offset of a compare channel
    function automatic logic [7:0] low_ofs(input int ch);
        return (ch == 0) ? `TOCP_OFS_CMP1_LO : `TOCP_OFS_CMP2_LO;
    endfunction

    // high byte offset of a compare channel
    function automatic logic [7:0] high_ofs(input int ch);
        return (ch == 0) ? `TOCP_OFS_CMP1_HI : `TOCP_OFS_CMP2_HI;
    endfunction

    // bus address phase accepted; only single word transfers are expected
    assign addr_phase = hsel & htrans[1] & hready;
    assign ap_addr    = {haddr[7:2], 2'b00};

    // mode decode: pwm wins over single pulse
    assign pwm_mode = s_reg.ctrl_two.pwm_sel;
    assign sp_mode  = s_reg.ctrl_two.sp_sel & ~s_reg.ctrl_two.pwm_sel;

    // valid trigger edge on capture pin one in single-pulse mode
    assign trig = sp_mode & (s_reg.ctrl_one.edge_one ? pin_rise[`TOCP_PIN_CAP1]
                                                     : pin_fall[`TOCP_PIN_CAP1]);

    // a match is judged in the cycle after the counter took its new value,
    // so flag and pin change while the counter holds the compare value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match[i] = s_reg.stepped & ~s_reg.inhibit[i]
                     & (s_reg.counter == s_reg.cmp[i]);
        end
    end

    // next state of the whole block
    always_comb begin
        s_next = s_reg;

        // zero-wait slave, always okay
        s_next.ready    = 1'b1;
        s_next.dp_write = addr_phase & hwrite;
        s_next.dp_addr  = ap_addr;
        s_next.reinit   = trig;

        // counter steps at the timer rate, trigger reloads the fixed value;
        // the first tick after a reload is swallowed so the restart value
        // lasts a whole count, which gives the pulse its extra count
        if (trig) begin
            s_next.counter = `TOCP_CNT_RELOAD;
            s_next.hold    = 1'b1;
        end else if (tick & s_reg.hold) begin
            s_next.hold    = 1'b0;
        end else if (tick) begin
            s_next.counter = s_reg.counter + `TOCP_CNT_ONE;
        end
        s_next.stepped = trig | (tick & ~s_reg.hold);

        // read side effects happen at the accepted address phase
        if (addr_phase & ~hwrite) begin
            s_next.rdata = read_word(ap_addr, s_reg);
            if (ap_addr == `TOCP_OFS_STATUS) begin
                s_next.armed = s_reg.armed | {s_reg.cap_flag, s_reg.flag};
            end
            for (int i = 0; i < 2; i++) begin
                if ((ap_addr == low_ofs(i)) && s_reg.armed[i]) begin
                    s_next.flag[i]  = 1'b0;
                    s_next.armed[i] = 1'b0;
                end
            end
            if ((ap_addr == `TOCP_OFS_CAP1_LO) && s_reg.armed[2]) begin
                s_next.cap_flag = 1'b0;
                s_next.armed[2] = 1'b0;
            end
        end

        // write data phase: hwdata stands in the cycle after the address
        if (s_reg.dp_write) begin
            case (s_reg.dp_addr)
                `TOCP_OFS_CTRL_ONE: begin
                    s_next.ctrl_one.level    = hwdata[1:0];
                    s_next.ctrl_one.cmp_ie   = hwdata[4];
                    s_next.ctrl_one.cap_ie   = hwdata[5];
                    s_next.ctrl_one.edge_one = hwdata[6];
                    // force bits act once and read back as zero
                    for (int i = 0; i < 2; i++) begin
                        if (hwdata[2 + i] & s_reg.ctrl_two.pin_en[i]
                            & ~sp_mode & ~pwm_mode) begin
                            s_next.pin[i] = hwdata[i];
                        end
                    end
                end
                `TOCP_OFS_CTRL_TWO: s_next.ctrl_two = hwdata[6:0];
                `TOCP_OFS_CAP1_LO: begin
                    if (s_reg.armed[2]) begin
                        s_next.cap_flag = 1'b0;
                        s_next.armed[2] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            for (int i = 0; i < 2; i++) begin
                if (s_reg.dp_addr == high_ofs(i)) begin
                    s_next.cmp[i][15:8] = hwdata[7:0];
                    s_next.inhibit[i]   = 1'b1;
                end
                if (s_reg.dp_addr == low_ofs(i)) begin
                    s_next.cmp[i][7:0] = hwdata[7:0];
                    s_next.inhibit[i]  = 1'b0;
                    s_next.flag[i]     = 1'b0;
                    s_next.armed[i]    = 1'b0;
                end
            end
        end

        // channel one: normal compare, or end of the single pulse
        if (match[0] & ~pwm_mode) begin
            if (~sp_mode) begin
                s_next.flag[0] = 1'b1;
            end
            if (s_reg.ctrl_two.pin_en[0]) begin
                s_next.pin[0] = s_reg.ctrl_one.level[0];
            end
        end

        // channel two: flag in any mode but pwm, pin only outside single pulse
        if (match[1] & ~pwm_mode) begin
            s_next.flag[1] = 1'b1;
            if (s_reg.ctrl_two.pin_en[1] & ~sp_mode) begin
                s_next.pin[1] = s_reg.ctrl_one.level[1];
            end
        end

        // pulse start wins over a same-step compare one match
        if (trig) begin
            s_next.cap_flag = 1'b1;
            s_next.cap_val  = `TOCP_CAP_TRIG_VAL;
            if (s_reg.ctrl_two.pin_en[0]) begin
                s_next.pin[0] = s_reg.ctrl_one.level[1];
            end
        end

        // shared request, gated by the enables and the cpu mask
        s_next.irq = ~cpu_irq_mask
                   & ((s_next.ctrl_one.cmp_ie & (|s_next.flag))
                   |  (s_next.ctrl_one.cap_ie & s_next.cap_flag));
    end

    // single register stage of the whole block; pins low during reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg        <= '0;
            s_reg.cmp[0] <= `TOCP_CMP_RESET;
            s_reg.cmp[1] <= `TOCP_CMP_RESET;
            s_reg.counter <= `TOCP_CNT_RELOAD;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output but hresp straight from the state register; hresp is tied to okay
    assign hreadyout              = s_reg.ready;
    assign hrdata                 = s_reg.rdata;
    assign hresp                  = 1'b0;
    assign compare_output_pin_one = s_reg.pin[0];
    assign compare_output_pin_two = s_reg.pin[1];
    assign compare_pin_enable     = s_reg.ctrl_two.pin_en;
    assign counter_reinit         = s_reg.reinit;
    assign timer_irq              = s_reg.irq;

    // hsize is accepted but only whole words are expected
    logic unused_size;
    assign unused_size = |hsize;
endmodule

// ===== verification/tocp_properties.sv
// concurrent checks on the ports of the compare block top module
`timescale 1ns/10ps
module tocp_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        cpu_irq_mask,
    input wire logic        compare_output_pin_one,
    input wire logic        compare_output_pin_two,
    input wire logic [1:0]  compare_pin_enable,
    input wire logic        counter_reinit,
    input wire logic        timer_irq
);
    logic       wr_ph;
    logic [7:0] wr_adr;
    logic [1:0] one_sh;
    logic [3:0] two_sh;
    logic       sp_on;

    // shadow of control writes, updated at the data phase edge like the slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph  <= 1'b0;
            wr_adr <= 8'h00;
            one_sh <= 2'h0;
            two_sh <= 4'h0;
        end else begin
            wr_ph  <= hsel & htrans[1] & hready & hwrite;
            wr_adr <= haddr[7:0];
            if (wr_ph && wr_adr == 8'h00) begin
                one_sh <= hwdata[1:0];
            end
            if (wr_ph && wr_adr == 8'h04) begin
                two_sh <= hwdata[3:0];
            end
        end
    end

    // pwm select overrides single-pulse select
    assign sp_on = two_sh[2] & ~two_sh[3];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // trigger step: reload strobe together with the pulse level on pin one
    sequence trig_s;
        counter_reinit ##0 compare_output_pin_one;
    endsequence

    AST_RESET_PINS: assert property ($rose(hresetn) |->
        !compare_output_pin_one && !compare_output_pin_two)
        else $error("compare pins not low after reset");
    AST_BUS_OKAY: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("slave not ready or response not okay");
    AST_IRQ_MASK: assert property ($past(cpu_irq_mask) |-> !timer_irq)
        else $error("interrupt raised while masked");
    AST_REINIT_ONE: assert property (counter_reinit |=> !counter_reinit)
        else $error("reload strobe longer than one cycle");
    AST_REINIT_LEVEL: assert property (counter_reinit |-> compare_output_pin_one == one_sh[1])
        else $error("pin one not at pulse level on trigger");
    AST_REINIT_MODE: assert property (counter_reinit |-> sp_on)
        else $error("counter reloaded outside single-pulse mode");
    AST_PULSE_HOLD: assert property (trig_s |=> $stable(compare_output_pin_one))
        else $error("pulse ended right after trigger");
    AST_PIN_EN: assert property (compare_pin_enable == two_sh[1:0])
        else $error("pin enables differ from control value");
    AST_SP_PIN_TWO: assert property (sp_on && $past(sp_on) && $past(sp_on, 2) |->
        $stable(compare_output_pin_two))
        else $error("pin two moved in single-pulse mode");
endmodule

bind tocp_top tocp_properties tocp_properties_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
    .hresp, .cpu_irq_mask, .compare_output_pin_one, .compare_output_pin_two,
    .compare_pin_enable, .counter_reinit, .timer_irq
);

// ===== verification/tocp_ext_model.sv
// far side model: trigger source on the capture pin and external count clock
`timescale 1ns/10ps
module tocp_ext_model (
    input  wire logic hclk,
    input  wire logic trig_lvl,
    input  wire logic ext_run,
    output logic      capture_input_pin_one,
    output logic      ext_clock_pin
);
    logic [1:0] half_cnt;

    // quiet pins at time zero
    initial begin
        capture_input_pin_one = 1'b0;
        ext_clock_pin = 1'b0;
        half_cnt = 2'h0;
    end

    // pin moves mid-cycle, unrelated to the sampling edge
    always @(negedge hclk) capture_input_pin_one <= trig_lvl;

    // toggle every 3 cycles: active edges 6 apart, stands still when not run
    always @(negedge hclk) begin
        if (!ext_run) begin
            half_cnt <= 2'h0;
        end else if (half_cnt == 2'h2) begin
            half_cnt      <= 2'h0;
            ext_clock_pin <= ~ext_clock_pin;
        end else begin
            half_cnt <= half_cnt + 2'h1;
        end
    end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the compare block over its ahb-lite port
`timescale 1ns/10ps
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, cpu_irq_mask, trig_lvl, ext_run;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0]  htrans, compare_pin_enable;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, ext_clock_pin, capture_input_pin_one, timer_irq;
    logic        compare_output_pin_one, compare_output_pin_two, counter_reinit;
    int          error_cnt, check_count, cyc, reinit_cnt, len, i, k, dv;

    tocp_top tocp_top_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cpu_irq_mask, .ext_clock_pin,
        .capture_input_pin_one, .compare_output_pin_one, .compare_output_pin_two,
        .compare_pin_enable, .counter_reinit, .timer_irq
    );
    tocp_ext_model tocp_ext_model_inst (
        .hclk, .trig_lvl, .ext_run, .capture_input_pin_one, .ext_clock_pin
    );

    // 25 MHz clock
    always #20 hclk = ~hclk;

    // verdict and end of run
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, well above the thousand or so cycles the tests need
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // count reload strobes seen at the pins
    always @(posedge hclk) begin
        if (counter_reinit === 1'b1) begin
            reinit_cnt++;
        end
    end

    // one single transfer: address phase held until ready, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {8'h00, e}, rd_q[15:0]);
    endtask

    // wait on the falling edge, where registered outputs have settled
    task automatic wait_irq();
        for (i = 0; i < 400 && timer_irq !== 1'b1; i++) @(negedge hclk);
        chk("irq", 16'h0001, 16'(timer_irq));
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        cpu_irq_mask = 1'b0;
        trig_lvl = 1'b0;
        ext_run = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, then read/write and an unmapped word
        rdchk(8'h0c, 8'h80);
        rdchk(8'h10, 8'h00);
        rdchk(8'h14, 8'h80);
        chk("pins", 16'h0000, 16'({compare_output_pin_two, compare_output_pin_one}));
        wr(8'h0c, 8'h12);
        wr(8'h10, 8'h34);
        rdchk(8'h0c, 8'h12);
        rdchk(8'h10, 8'h34);
        rdchk(8'h3c, 8'h00);
        // both channels match the same count, pins enabled, levels high
        wr(8'h04, 8'h03);
        wr(8'h00, 8'h13);
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'h40);
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h40);
        wait_irq();
        chk("pins", 16'h0003, 16'({compare_output_pin_two, compare_output_pin_one}));
        @(posedge hclk);
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("masked irq", 16'h0000, 16'(timer_irq));
        @(posedge hclk);
        cpu_irq_mask <= 1'b0;
        // low byte read clears only a flag seen set in status, a low byte write clears it always
        wr(8'h10, 8'h40);
        xfer(1'b0, 8'h18, 8'h00);
        rdchk(8'h08, 8'h02);
        wr(8'h10, 8'h40);
        rdchk(8'h08, 8'h02);
        xfer(1'b0, 8'h18, 8'h00);
        rdchk(8'h08, 8'h00);
        // forced levels: pins follow, no flag
        wr(8'h00, 8'h1c);
        @(negedge hclk);
        chk("forced pins", 16'h0000, 16'({compare_output_pin_two, compare_output_pin_one}));
        rdchk(8'h08, 8'h00);
        // high byte write holds off compares until the low byte
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h12);
        wr(8'h14, 8'h00);
        xfer(1'b0, 8'h08, 8'h00);
        wr(8'h18, 8'h90);
        wr(8'h14, 8'h00);
        repeat (160) @(posedge hclk);
        rdchk(8'h08, 8'h00);
        wr(8'h14, 8'h00);
        xfer(1'b0, 8'h08, 8'h00);
        wr(8'h18, 8'hf0);
        wait_irq();
        rdchk(8'h08, 8'h02);
        chk("pin two", 16'h0000, 16'(compare_output_pin_two));
        // single pulse at every count rate, ext clock last
        wr(8'h00, 8'h62);
        rdchk(8'h00, 8'h62);
        wr(8'h18, 8'hf0);
        wr(8'h04, 8'h45);
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'h10);
        for (k = 0; k < 4; k++) begin
            dv = (k == 3) ? 6 : (2 << k);
            wr(8'h04, 8'h45 | 8'(k << 4));
            ext_run  <= (k == 3);
            trig_lvl <= 1'b1;
            for (i = 0; i < 50 && counter_reinit !== 1'b1; i++) @(negedge hclk);
            for (len = 0; len < 400 && compare_output_pin_one === 1'b1; len++) @(negedge hclk);
            chk("pulse length", 16'h0001, 16'(len >= 20 * dv && len <= 22 * dv));
            chk("capture irq", 16'h0001, 16'(timer_irq));
            rdchk(8'h08, 8'h04);
            rdchk(8'h1c, 8'hff);
            rdchk(8'h20, 8'hfd);
            rdchk(8'h08, 8'h00);
            trig_lvl <= 1'b0;
            repeat (10) @(posedge hclk);
        end
        ext_run <= 1'b0;
        // force bit ignored in single-pulse mode
        wr(8'h00, 8'h67);
        @(negedge hclk);
        chk("pin one", 16'h0000, 16'(compare_output_pin_one));
        // pwm with single-pulse: trigger has no effect
        wr(8'h04, 8'h4d);
        len = reinit_cnt;
        @(posedge hclk);
        trig_lvl <= 1'b1;
        repeat (20) @(posedge hclk);
        @(negedge hclk);
        chk("reload count", 16'(len), 16'(reinit_cnt));
        complete_run();
    end
endmodule
